// ==== common/hsbfc_defs.vh ====
// shared constants for the host serial buffer and flow control block
// assumes the includer sets nothing; definitions only
`ifndef HSBFC_DEFS_VH
`define HSBFC_DEFS_VH
`define HSBFC_CLK_HZ        25000000
`define HSBFC_BAUD_DEF      9600
`define HSBFC_DATA_BITS     8
`define HSBFC_CTS_RESUME    34
`define HSBFC_XOFF_CHAR     8'h13
`define HSBFC_XON_CHAR      8'h11
`define HSBFC_RTS_FLOW      3'h2
`define HSBFC_PK_DEF        8'h40
`define HSBFC_IN_DEPTH      256
`define HSBFC_OUT_DEPTH     256
`define HSBFC_FT_DEF        9'h0E0
`endif

// ==== hdl/hsbfc_bitclk.v ====
// baud tick generator: one pulse per sixteenth of a bit period
// assumes divisor is held steady while the link is idle
`timescale 1ns/10ps
`default_nettype none
module hsbfc_bitclk #(
  parameter W = 16
) (
  // clock and reset
  input  wire         mclk,
  input  wire         srst,
  // divisor in clocks per sixteenth bit, minus one
  input  wire [W-1:0] div16,
  // ticks
  output reg          tick16
);
  reg [W-1:0] cnt_reg;
  // free running so receiver sampling stays phase-free of frames
  always @(posedge mclk) begin
    if (srst) begin
      cnt_reg <= {W{1'b0}};
      tick16  <= 1'b0;
    end else if (cnt_reg >= div16) begin
      cnt_reg <= {W{1'b0}};
      tick16  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      tick16  <= 1'b0;
    end
  end
endmodule // hsbfc_bitclk
`default_nettype wire

// ==== hdl/hsbfc_top.v ====
// host serial port: input buffer with packetizing and cts, output buffer
// with rts and xon/xoff gating. radio side is a simple byte handshake.
`timescale 1ns/10ps
`default_nettype none
`include "hsbfc_defs.vh"
module hsbfc_top #(
  parameter IN_DEPTH  = `HSBFC_IN_DEPTH,
  parameter OUT_DEPTH = `HSBFC_OUT_DEPTH,
  parameter AW        = 8
) (
  // clock and reset
  input  wire        mclk,
  input  wire        srst,
  // host pins
  input  wire        serial_input_line,
  output reg         serial_output_line,
  output reg         cts_n,
  input  wire        rts_n,
  // configuration
  input  wire [15:0] serial_baud_setting,
  input  wire [7:0]  packet_byte_threshold,
  input  wire [15:0] packetization_timeout,
  input  wire [7:0]  max_radio_packet_size,
  input  wire        parity_setting,
  input  wire [8:0]  flow_stop_threshold,
  input  wire [2:0]  rts_pin_function,
  input  wire        software_flow_enable,
  input  wire        command_seq_seen,
  // radio side
  input  wire        radio_rx_busy,
  output reg         tx_request,
  output wire        tx_valid,
  output reg  [7:0]  tx_data,
  input  wire        tx_ready,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  output reg         rx_dropped,
  // status
  output reg  [8:0]  in_level,
  output reg  [8:0]  out_level
);
  function [AW-1:0] inc;
    input [AW-1:0] p;
    begin
      inc = p + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  wire tick16;
  hsbfc_bitclk #(.W(16)) u_bitclk (
    .mclk   (mclk),
    .srst   (srst),
    .div16  (serial_baud_setting),
    .tick16 (tick16)
  );

  // two-flop input synchronisers
  reg rxd_s1_reg, rxd_reg, rts_s1_reg, rts_reg;
  always @(posedge mclk) begin
    if (srst) begin
      rxd_s1_reg <= 1'b1;
      rxd_reg    <= 1'b1;
      rts_s1_reg <= 1'b1;
      rts_reg    <= 1'b1;
    end else begin
      rxd_s1_reg <= serial_input_line;
      rxd_reg    <= rxd_s1_reg;
      rts_s1_reg <= rts_n;
      rts_reg    <= rts_s1_reg;
    end
  end

  // receiver: 16x oversampled, mid-bit sampling
  reg [1:0] rs_reg;
  reg [3:0] rph_reg;
  reg [3:0] rbit_reg;
  reg [7:0] rsh_reg;
  reg       rdone_reg;
  localparam RS_IDLE = 2'h0, RS_START = 2'h1, RS_DATA = 2'h2, RS_STOP = 2'h3;
  always @(posedge mclk) begin
    if (srst) begin
      rs_reg <= RS_IDLE; rph_reg <= 4'h0; rbit_reg <= 4'h0;
      rsh_reg <= 8'h00; rdone_reg <= 1'b0;
    end else begin
      rdone_reg <= 1'b0;
      if (tick16) begin
        rph_reg <= rph_reg + 4'h1;
        case (rs_reg)
          RS_IDLE: if (!rxd_reg) begin
            rs_reg <= RS_START; rph_reg <= 4'h0;
          end
          RS_START: if (rph_reg == 4'h7) begin
            // glitch shorter than half a bit is rejected
            rs_reg   <= rxd_reg ? RS_IDLE : RS_DATA;
            rph_reg  <= 4'h0;
            rbit_reg <= 4'h0;
          end
          RS_DATA: if (rph_reg == 4'hF) begin
            rsh_reg  <= {rxd_reg, rsh_reg[7:1]}; // lsb first
            rbit_reg <= rbit_reg + 4'h1;
            if (rbit_reg == `HSBFC_DATA_BITS - 1) rs_reg <= RS_STOP;
          end
          RS_STOP: if (rph_reg == 4'hF) begin
            rs_reg    <= RS_IDLE;
            rdone_reg <= rxd_reg; // framing error drops byte
          end
          default: rs_reg <= RS_IDLE;
        endcase
      end
    end
  end

  // input buffer capacity from packet size and parity
  wire [8:0] in_cap = parity_setting ? {1'b0, max_radio_packet_size} + 9'h010
                                     : {max_radio_packet_size, 1'b0};
  localparam [8:0] IN_LIM_MAX = IN_DEPTH[8:0];
  wire [8:0] in_lim = (in_cap > IN_LIM_MAX) ? IN_LIM_MAX : in_cap;

  reg [7:0]    in_mem [0:IN_DEPTH-1];
  reg [AW-1:0] iw_reg, ir_reg;
  wire in_full  = (in_level >= in_lim);
  wire in_empty = (in_level == 9'h000);
  // flow characters steer the output side and never become payload
  wire flow_char = software_flow_enable
                   && (rsh_reg == `HSBFC_XOFF_CHAR || rsh_reg == `HSBFC_XON_CHAR);
  wire in_push  = rdone_reg && !in_full && !flow_char;
  wire in_pop   = tx_valid && tx_ready;
  assign tx_valid = tx_request && !in_empty && !radio_rx_busy;

  always @(posedge mclk) begin
    if (in_push) in_mem[iw_reg] <= rsh_reg;
  end
  // input buffer pointers, level and transmit data register
  always @(posedge mclk) begin
    if (srst) begin
      iw_reg <= {AW{1'b0}}; ir_reg <= {AW{1'b0}};
      in_level <= 9'h000; tx_data <= 8'h00;
    end else begin
      if (in_push) iw_reg <= inc(iw_reg);
      if (in_pop)  ir_reg <= inc(ir_reg);
      in_level <= in_level + {8'h00, in_push} - {8'h00, in_pop};
      tx_data  <= in_mem[in_pop ? inc(ir_reg) : ir_reg];
    end
  end

  // idle timer counts sixteenth-bit ticks of silence on the line, 160 per character time
  reg [19:0] idle_reg;
  reg        timeout_hit;
  wire [19:0] to_ticks = {packetization_timeout, 4'h0} * 20'd10;
  always @(posedge mclk) begin
    if (srst) begin
      idle_reg <= 20'h00000; timeout_hit <= 1'b0;
    end else begin
      if (rdone_reg || rs_reg != RS_IDLE) idle_reg <= 20'h00000;
      else if (tick16 && idle_reg != 20'hFFFFF) idle_reg <= idle_reg + 20'h00001;
      timeout_hit <= (packetization_timeout != 16'h0000)
                     && (idle_reg >= to_ticks);
    end
  end

  wire thr_on  = (packet_byte_threshold != 8'h00);
  wire [7:0] thr_val = (packet_byte_threshold > max_radio_packet_size)
                 ? max_radio_packet_size : packet_byte_threshold;
  wire thr_hit = thr_on && (in_level >= {1'b0, thr_val});
  wire pk_hit  = (in_level >= {1'b0, max_radio_packet_size});
  // transmission request held until the buffer empties
  always @(posedge mclk) begin
    if (srst) tx_request <= 1'b0;
    else if (in_empty) tx_request <= 1'b0;
    else if (thr_hit || timeout_hit || pk_hit || command_seq_seen)
      tx_request <= 1'b1;
  end

  // cts: stop early at the threshold or full, resume at 34 free
  wire [8:0] in_free = in_lim - in_level;
  always @(posedge mclk) begin
    if (srst) cts_n <= 1'b0;
    else if (in_full || in_level >= flow_stop_threshold)
      cts_n <= 1'b1;
    else if (in_free >= `HSBFC_CTS_RESUME)
      cts_n <= 1'b0;
  end

  // output buffer from radio; overflowing bytes are lost
  reg [7:0]    out_mem [0:OUT_DEPTH-1];
  reg [AW-1:0] ow_reg, or_reg;
  wire out_full  = (out_level == OUT_DEPTH);
  wire out_push  = rx_valid && !out_full;
  reg  out_pop;
  always @(posedge mclk) begin
    if (out_push) out_mem[ow_reg] <= rx_data;
  end

  // xon/xoff state from host characters, which are swallowed
  reg xoff_reg;
  always @(posedge mclk) begin
    if (srst) xoff_reg <= 1'b0;
    else if (!software_flow_enable) xoff_reg <= 1'b0;
    else if (rdone_reg && rsh_reg == `HSBFC_XOFF_CHAR) xoff_reg <= 1'b1;
    else if (rdone_reg && rsh_reg == `HSBFC_XON_CHAR)  xoff_reg <= 1'b0;
  end

  wire hold_out = (rts_pin_function == `HSBFC_RTS_FLOW && rts_reg)
                  || xoff_reg;

  // transmitter: 10 bits, each 16 sub ticks
  reg [3:0] tph_reg, tbit_reg;
  reg [9:0] tsh_reg;
  reg       tbusy_reg;
  always @(posedge mclk) begin
    if (srst) begin
      tph_reg <= 4'h0; tbit_reg <= 4'h0; tsh_reg <= 10'h3FF;
      tbusy_reg <= 1'b0; serial_output_line <= 1'b1; out_pop <= 1'b0;
    end else begin
      out_pop <= 1'b0;
      if (!tbusy_reg) begin
        serial_output_line <= 1'b1;
        if (out_level != 9'h000 && !hold_out && !out_pop) begin
          tsh_reg   <= {1'b1, out_mem[or_reg], 1'b0};
          tbusy_reg <= 1'b1;
          out_pop   <= 1'b1;
          tph_reg   <= 4'h0;
          tbit_reg  <= 4'h0;
        end
      end else if (tick16) begin
        serial_output_line <= tsh_reg[0];
        tph_reg <= tph_reg + 4'h1;
        if (tph_reg == 4'hF) begin
          tsh_reg  <= {1'b1, tsh_reg[9:1]};
          tbit_reg <= tbit_reg + 4'h1;
          if (tbit_reg == 4'h9) tbusy_reg <= 1'b0;
        end
      end
    end
  end

  // output pointers, level and drop flag
  always @(posedge mclk) begin
    if (srst) begin
      ow_reg <= {AW{1'b0}}; or_reg <= {AW{1'b0}};
      out_level <= 9'h000; rx_dropped <= 1'b0;
    end else begin
      if (out_push) ow_reg <= inc(ow_reg);
      if (out_pop)  or_reg <= inc(or_reg);
      out_level  <= out_level + {8'h00, out_push} - {8'h00, out_pop};
      rx_dropped <= rx_valid && out_full;
    end
  end
endmodule // hsbfc_top
`default_nettype wire

// ==== verification/hsbfc_props.sv ====
// checker: port-level relations of the host serial block
// assumes it is bound to hsbfc_top and sees its ports only
`timescale 1ns/10ps
`default_nettype none
module hsbfc_props (
  // clock and reset
  input wire logic       mclk,
  input wire logic       srst,
  // host side
  input wire logic       serial_output_line,
  input wire logic       cts_n,
  // configuration
  input wire logic       parity_setting,
  input wire logic [7:0] max_radio_packet_size,
  input wire logic [7:0] packet_byte_threshold,
  input wire logic [8:0] flow_stop_threshold,
  // radio side and status
  input wire logic       radio_rx_busy,
  input wire logic       tx_request,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       rx_valid,
  input wire logic       rx_dropped,
  input wire logic [8:0] in_level,
  input wire logic [8:0] out_level
);
  logic [9:0] cap;
  // input capacity, capped at 256 bytes
  always_comb begin
    cap = parity_setting ? {2'b0, max_radio_packet_size} + 10'h010
                         : {1'b0, max_radio_packet_size, 1'b0};
    if (cap > 10'h100) cap = 10'h100;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  reset_idle_a: assert property ($fell(srst) |-> serial_output_line && !cts_n)
    else $error("outputs not idle after reset");
  busy_holds_a: assert property (radio_rx_busy |-> !tx_valid)
    else $error("transfer while radio busy");
  valid_cause_a: assert property (tx_valid |-> tx_request && in_level != 9'h000)
    else $error("transfer without release");
  drop_pulse_a: assert property (rx_valid && out_level == 9'h100 |=> rx_dropped)
    else $error("no drop flag on full buffer");
  out_growth_a: assert property (!rx_valid |=> out_level <= $past(out_level))
    else $error("output level grew without input");
  in_pop_a: assert property (tx_valid && tx_ready |=> in_level <= $past(in_level))
    else $error("input level grew on pop");
  cts_stop_a: assert property (in_level >= flow_stop_threshold |-> ##[0:2] cts_n)
    else $error("cts not raised at threshold");
  cts_resume_a: assert property (!$past(srst) && $fell(cts_n)
    |-> cap >= {1'b0, $past(in_level)} + 10'd34) else $error("cts resumed early");
  thresh_rel_a: assert property (packet_byte_threshold != 8'h00
    && packet_byte_threshold <= max_radio_packet_size
    && in_level >= {1'b0, packet_byte_threshold} |-> ##[0:3] tx_request)
    else $error("threshold did not release");
endmodule // hsbfc_props
bind hsbfc_top hsbfc_props chk (.*);
`default_nettype wire

// ==== verification/hsbfc_host.sv ====
// host uart model: frames bytes into the device, collects its output
// assumes the bench sets BP to the device bit period in clocks
`timescale 1ns/10ps
`default_nettype none
module hsbfc_host #(
  parameter int BP = 32
) (
  // clock
  input  wire logic mclk,
  // serial pins
  output var  logic to_dev,
  input  wire logic from_dev,
  input  wire logic cts_n
);
  logic [7:0] rxq[$];
  logic [7:0] sh;
  initial to_dev = 1'b1; // idle high between characters
  // start low, lsb first, stop high; holds off while cts is high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (cts_n !== 1'b0) @(negedge mclk);
    for (int j = 0; j < 10; j++) begin
      to_dev = f[j];
      repeat (BP) @(negedge mclk);
    end
  endtask
  // mid-bit sampling; a low stop bit drops the byte
  always begin
    @(negedge from_dev);
    repeat (BP / 2) @(posedge mclk);
    for (int j = 0; j < 9; j++) begin
      repeat (BP) @(posedge mclk);
      if (j < 8) sh[j] = from_dev;
      else if (from_dev) rxq.push_back(sh);
    end
  end
endmodule // hsbfc_host
`default_nettype wire

// ==== verification/tb.sv ====
// testbench: host model on the serial pins, bench drives the radio side
// assumes a bit period of 32 clocks (baud setting 1)
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk = 1'b0, srst, rts_n, parity_setting, software_flow_enable;
  logic command_seq_seen, radio_rx_busy, tx_ready, rx_valid;
  logic [15:0] serial_baud_setting, packetization_timeout;
  logic [7:0] packet_byte_threshold, max_radio_packet_size, rx_data;
  logic [8:0] flow_stop_threshold;
  logic [2:0] rts_pin_function;
  wire logic serial_input_line, serial_output_line, cts_n, tx_request, tx_valid;
  wire logic rx_dropped;
  wire logic [7:0] tx_data;
  wire logic [8:0] in_level, out_level;
  logic [7:0] pat[4] = '{8'h1F, 8'hA5, 8'h80, 8'h01};
  int n_mismatch = 0, n_tests = 0, k, w;
  always #20 mclk = ~mclk;
  hsbfc_top DUT (.*);
  hsbfc_host #(.BP(32)) host (.mclk(mclk), .to_dev(serial_input_line),
    .from_dev(serial_output_line), .cts_n(cts_n));
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // take one radio byte; tx_data moves to the next entry on the pop edge, then idle a cycle
  task automatic pop(input logic [7:0] e);
    for (w = 0; w < 2000 && tx_valid !== 1'b1; w++) cyc(1);
    chk({1'b0, tx_data}, {1'b0, e});
    tx_ready = 1'b1;
    cyc(1);
    tx_ready = 1'b0;
    cyc(1);
  endtask
  task automatic push(input logic [7:0] b);
    rx_data = b;
    rx_valid = 1'b1;
    cyc(1);
    rx_valid = 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the sequence needs about 20000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    final_report;
  end
  initial begin
    {srst, radio_rx_busy, parity_setting} = 3'b111;
    {rts_n, command_seq_seen, tx_ready, rx_valid, software_flow_enable} = 5'h00;
    serial_baud_setting = 16'h0001; // host baud kept below radio rate
    packetization_timeout = 16'h0000;
    {packet_byte_threshold, max_radio_packet_size, rx_data} = 24'h042800;
    flow_stop_threshold = 9'h028;
    rts_pin_function = 3'h0;
    cyc(2);
    srst = 1'b0;
    cyc(1);
    chk(serial_output_line, 1'b1);
    chk(cts_n, 1'b0);
    // threshold reached while the radio receives: held, then sent in order
    for (k = 0; k < 3; k++) host.send(pat[k]);
    cyc(3);
    chk(tx_request, 1'b0);
    host.send(pat[3]);
    cyc(3);
    chk(in_level, 9'h004);
    chk(tx_request, 1'b1);
    chk(tx_valid, 1'b0);
    radio_rx_busy = 1'b0;
    for (k = 0; k < 4; k++) pop(pat[k]);
    // idle timeout of two character times, threshold off
    {packet_byte_threshold, packetization_timeout} = 24'h000002;
    host.send(8'h55);
    cyc(500);
    chk(tx_request, 1'b0);
    cyc(300);
    chk(tx_request, 1'b1);
    pop(8'h55);
    // both conditions off: only the command sequence releases
    packetization_timeout = 16'h0000;
    host.send(8'h3C);
    cyc(1000);
    chk(tx_request, 1'b0);
    command_seq_seen = 1'b1;
    cyc(1);
    command_seq_seen = 1'b0;
    cyc(3);
    chk(tx_request, 1'b1);
    pop(8'h3C);
    // cts stops the host early, resumes only with 34 bytes free
    radio_rx_busy = 1'b1;
    for (k = 0; k < 40; k++) host.send(k[7:0]);
    cyc(3);
    chk(cts_n, 1'b1);
    radio_rx_busy = 1'b0;
    for (k = 0; k < 40; k++) begin
      pop(k[7:0]);
      cyc(1);
      chk(cts_n, (39 - k) > 22);
    end
    // rts gating, then output overflow while held off
    rts_pin_function = 3'h2;
    rts_n = 1'b1;
    cyc(4);
    push(8'hC3);
    cyc(700);
    chk(host.rxq.size(), 9'h000);
    rts_n = 1'b0;
    cyc(400);
    chk(host.rxq.pop_front(), 9'h0C3);
    rts_n = 1'b1;
    cyc(4);
    rx_valid = 1'b1;
    for (k = 0; k < 257; k++) begin
      rx_data = k[7:0];
      cyc(1);
    end
    rx_valid = 1'b0;
    chk(rx_dropped, 1'b1);
    chk(out_level, 9'h100);
    // second reset clears the buffers; then xoff and xon from the host
    srst = 1'b1;
    cyc(2);
    {srst, rts_pin_function, software_flow_enable} = 5'h01;
    cyc(1);
    chk(out_level, 9'h000);
    host.send(8'h13);
    cyc(4);
    push(8'h7E);
    cyc(700);
    chk(host.rxq.size(), 9'h000);
    host.send(8'h11);
    cyc(400);
    chk(host.rxq.pop_front(), 9'h07E);
    chk(in_level, 9'h000);
    final_report;
  end
endmodule // tb
`default_nettype wire
